// ---- hw/tpc_clk_loss.sv ----
// Purpose: Transmit line clock presence detector
// Assumes: Pin is asynchronous to clk
// Notes: Loss is a level, high while no edge seen in LOSS_CYC cycles
`default_nettype none
module tpc_clk_loss
#(
   parameter int LOSS_CYC = tpc_pkg::LOSS_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic line_clk_pin,
   output logic clk_lost
);
   import tpc_pkg::*;
   typedef struct packed
   {
      logic [2:0] sync;
      logic level;
      logic [11:0] idle;
      logic lost;
   } tpc_cl_s;
   tpc_cl_s cl_ff;
   tpc_cl_s nxt_cl;
   // ****************************************
   // Sync, idle cycle count and loss
   // ****************************************
   always_comb
   begin
      nxt_cl = cl_ff;
      nxt_cl.sync = {cl_ff.sync[1:0], line_clk_pin};
      if (cl_ff.sync[2] == cl_ff.sync[1] && cl_ff.sync[2] != cl_ff.level)
      begin
         nxt_cl.level = cl_ff.sync[2];
         nxt_cl.idle = 12'h000;
         nxt_cl.lost = 1'b0;
      end
      else if (cl_ff.idle >= 12'(LOSS_CYC - 1))
      begin
         nxt_cl.lost = 1'b1;
      end
      else
      begin
         nxt_cl.idle = cl_ff.idle + 12'h001;
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cl_ff <= '0;
      end
      else
      begin
         cl_ff <= nxt_cl;
      end
   end
   assign clk_lost = cl_ff.lost;
endmodule
`default_nettype wire

// ---- hw/tpc_pkg.sv ----
// Purpose: Constants for the transmit port control and status bank
// Assumes: 125 MHz clk, 8-bit register port, synchronous reset
// Notes: Offsets are byte addresses on the register port
//
// Summary of operation
// - Interleave mode bit: 0 channel interleave, 1 frame interleave.
// - Interleave enable bit: 0 bus operation off, 1 on.
// - Three-bit position field k places device at bus position k+1.
// - Five-bit select picks monitored channel; 0 is channel 1, 31 channel 32.
// - Test port direction 0 feeds transmit path, 1 feeds receive path.
// - Unframed select 0 skips framing bits, 1 also fills framing bits.
// - Test port enable 0 idles the port, 1 activates it.
// - Each suppress bit excludes its channel bit; bit 7 is channel MSB.
// - In E1 only, CRC-4 bit makes synchronizer search the multiframe word.
// - Synchronizer runs only while its enable bit is one.
// - Auto resync bit is inverted: 0 enables, 1 disables.
// - Resync starts only on a 0-to-1 write; software must clear first.
// - Every latched status bit is a sticky event able to interrupt.
// - Full flag sets when the elastic store fills and deletes a frame.
// - Empty flag sets when the elastic store empties and repeats a frame.
// - Slip flag sets on any frame repeat or delete.
// - T1 carrier flag sets once per 72 frames when enabled.
// - T1 bit 3 flags a pulse-density violation of transmit data.
// - E1 bit 3 sets every 250 us for align frame updates.
// - Multiframe flag: D4 1.5 ms, ESF 3 ms, E1 2 ms.
// - Restored flag sets when transmit clock loss ends.
// - Loss flag sets after 3 idle clock periods, holds while lost.
// - Bus size codes 00,01,10 mean 2,4,8 devices; 11 reserved.
`default_nettype none
package tpc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_IBUS = 12'h188;
   localparam logic [11:0] OFS_MON_SEL = 12'h189;
   localparam logic [11:0] OFS_TEST_CTRL = 12'h18A;
   localparam logic [11:0] OFS_SUPPRESS = 12'h18B;
   localparam logic [11:0] OFS_SYNC_CTRL = 12'h18E;
   localparam logic [11:0] OFS_STATUS = 12'h190;
   localparam logic [11:0] OFS_MON_VALUE = 12'h1F0;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] MSK_IBUS = 8'h7F;
   localparam logic [7:0] MSK_MON_SEL = 8'h1F;
   localparam logic [7:0] MSK_TEST_CTRL = 8'h07;
   localparam logic [7:0] MSK_SYNC_CTRL = 8'h0F;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int IB_SIZE_LSB = 5;
   localparam int IB_MODE_BIT = 4;
   localparam int IB_EN_BIT = 3;
   localparam int IB_POS_LSB = 0;
   localparam int TP_DIR_BIT = 2;
   localparam int TP_UNFR_BIT = 1;
   localparam int TP_EN_BIT = 0;
   localparam int SY_CRC4_BIT = 3;
   localparam int SY_EN_BIT = 2;
   localparam int SY_NOAUTO_BIT = 1;
   localparam int SY_RESYNC_BIT = 0;
   localparam int ST_FULL = 7;
   localparam int ST_EMPTY = 6;
   localparam int ST_SLIP = 5;
   localparam int ST_CARRIER = 4;
   localparam int ST_DENS_ALIGN = 3;
   localparam int ST_MF = 2;
   localparam int ST_RESTORED = 1;
   localparam int ST_LOSS = 0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int TX_CLK_PERIOD_NS = 648;
   localparam int LOSS_PERIODS = 3;
   localparam int LOSS_CYC =
      (LOSS_PERIODS * TX_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FRAME_US = 125;
   localparam int ALIGN_US = 250;
   localparam int D4_MF_US = 1500;
   localparam int ESF_MF_US = 3000;
   localparam int E1_MF_US = 2000;
   localparam int ALIGN_FRAMES = ALIGN_US / FRAME_US;
   localparam int D4_FRAMES = D4_MF_US / FRAME_US;
   localparam int ESF_FRAMES = ESF_MF_US / FRAME_US;
   localparam int E1_FRAMES = E1_MF_US / FRAME_US;
   localparam int CARRIER_FRAMES = 72;
   localparam int FRAME_WRAP = 144;
   localparam int PDV_MAX_ZEROS = 15;
   // ****************************************
   // Synchronizer states
   // ****************************************
   typedef enum logic [2:0]
   {
      SY_OFF = 3'b001,
      SY_HUNT = 3'b010,
      SY_LOCK = 3'b100
   } tpc_sync_e;
endpackage
`default_nettype wire

// ---- hw/tpc_port_ctrl.sv ----
// Purpose: Transmit port control and latched status registers
// Assumes: Framer events are one-cycle pulses on clk
// Notes: Status register is write-one-to-clear, set wins
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module tpc_port_ctrl
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [tpc_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic e1_mode,
   input wire logic esf_mode,
   input wire logic carrier_mf_enable,
   input wire logic frame_pulse,
   input wire logic es_delete_evt,
   input wire logic es_repeat_evt,
   input wire logic tx_data_bit,
   input wire logic tx_bit_valid,
   input wire logic [2:0] tx_bit_pos,
   input wire logic tx_fbit_slot,
   input wire logic [4:0] tx_chan_num,
   input wire logic [7:0] tx_chan_data,
   input wire logic tx_chan_valid,
   input wire logic sync_found,
   input wire logic sync_lost,
   input wire logic tx_line_clock_input,
   output logic interleave_mode_select,
   output logic interleave_bus_enable,
   output logic [2:0] bus_position_field,
   output logic [1:0] bus_size_field,
   output logic [3:0] bus_device_count,
   output logic bus_position_ok,
   output logic [4:0] monitor_channel_select,
   output logic [7:0] channel_monitor_value,
   output logic test_port_direction,
   output logic test_port_unframed_select,
   output logic test_port_enable,
   output logic tp_insert_tx,
   output logic tp_insert_rx,
   output logic tx_synchronizer_enable,
   output logic crc4_search,
   output logic auto_resync_en,
   output logic resync_pulse,
   output logic sync_searching,
   output logic [7:0] status_pending
);
   import tpc_pkg::*;
   typedef struct packed
   {
      logic [7:0] ibus;
      logic [7:0] mon_sel;
      logic [7:0] tctl;
      logic [7:0] supp;
      logic [7:0] sctl;
      logic [7:0] status;
      logic [7:0] mon_val;
      logic [7:0] rdata;
      logic [7:0] fc;
      logic [4:0] zrun;
      logic lost_d;
      logic resync;
      tpc_sync_e sync;
   } tpc_state_s;
   tpc_state_s st_ff;
   tpc_state_s nxt_st;
   logic clk_lost;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic wr_ibus;
   logic wr_sync;
   logic last_frame;
   // ****************************************
   // Frame count decode
   // ****************************************
   function automatic logic tpc_at_end(input logic [7:0] fc, input int n);
      return (int'(fc) % n) == (n - 1);
   endfunction
   // ****************************************
   // Clock loss detector
   // ****************************************
   tpc_clk_loss #(.LOSS_CYC(LOSS_CYC)) u_loss
   (
      .clk(clk),
      .rstn(rstn),
      .line_clk_pin(tx_line_clock_input),
      .clk_lost(clk_lost)
   );
   // ****************************************
   // Event sources
   // ****************************************
   always_comb
   begin
      set_v = 8'h00;
      set_v[ST_FULL] = es_delete_evt;
      set_v[ST_EMPTY] = es_repeat_evt;
      set_v[ST_SLIP] = es_delete_evt | es_repeat_evt;
      set_v[ST_CARRIER] = !e1_mode && carrier_mf_enable && frame_pulse
         && tpc_at_end(st_ff.fc, CARRIER_FRAMES);
      if (e1_mode)
      begin
         set_v[ST_DENS_ALIGN] = frame_pulse
            && tpc_at_end(st_ff.fc, ALIGN_FRAMES);
         set_v[ST_MF] = frame_pulse
            && tpc_at_end(st_ff.fc, E1_FRAMES);
      end
      else
      begin
         set_v[ST_DENS_ALIGN] = tx_bit_valid && !tx_data_bit
            && st_ff.zrun == 5'(PDV_MAX_ZEROS);
         set_v[ST_MF] = frame_pulse && tpc_at_end(st_ff.fc,
            esf_mode ? ESF_FRAMES : D4_FRAMES);
      end
      set_v[ST_RESTORED] = st_ff.lost_d && !clk_lost;
      set_v[ST_LOSS] = clk_lost;
   end
   assign last_frame = st_ff.fc == 8'(FRAME_WRAP - 1);
   assign wr_ibus = wr_en && addr == OFS_IBUS;
   assign wr_sync = wr_en && addr == OFS_SYNC_CTRL;
   assign clr_v = (wr_en && addr == OFS_STATUS) ? wdata : 8'h00;
   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.resync = 1'b0;
      nxt_st.lost_d = clk_lost;
      nxt_st.status = (st_ff.status & ~clr_v) | set_v;
      if (frame_pulse)
      begin
         nxt_st.fc = last_frame ? 8'h00 : st_ff.fc + 8'h01;
      end
      if (tx_bit_valid)
      begin
         if (tx_data_bit)
         begin
            nxt_st.zrun = 5'h00;
         end
         else if (st_ff.zrun != 5'(PDV_MAX_ZEROS))
         begin
            nxt_st.zrun = st_ff.zrun + 5'h01;
         end
      end
      if (tx_chan_valid && tx_chan_num == st_ff.mon_sel[4:0])
      begin
         nxt_st.mon_val = tx_chan_data;
      end
      if (wr_ibus)
      begin
         nxt_st.ibus = wdata & MSK_IBUS;
      end
      if (wr_en && addr == OFS_MON_SEL)
      begin
         nxt_st.mon_sel = wdata & MSK_MON_SEL;
      end
      if (wr_en && addr == OFS_TEST_CTRL)
      begin
         nxt_st.tctl = wdata & MSK_TEST_CTRL;
      end
      if (wr_en && addr == OFS_SUPPRESS)
      begin
         nxt_st.supp = wdata;
      end
      if (wr_sync)
      begin
         nxt_st.sctl = wdata & MSK_SYNC_CTRL;
         nxt_st.resync = wdata[SY_RESYNC_BIT]
            && !st_ff.sctl[SY_RESYNC_BIT] && wdata[SY_EN_BIT];
      end
      unique case (st_ff.sync)
         SY_OFF:
         begin
            if (st_ff.sctl[SY_EN_BIT])
            begin
               nxt_st.sync = SY_HUNT;
            end
         end
         SY_HUNT:
         begin
            if (!st_ff.sctl[SY_EN_BIT])
            begin
               nxt_st.sync = SY_OFF;
            end
            else if (sync_found && !st_ff.resync)
            begin
               nxt_st.sync = SY_LOCK;
            end
         end
         SY_LOCK:
         begin
            if (!st_ff.sctl[SY_EN_BIT])
            begin
               nxt_st.sync = SY_OFF;
            end
            else if (st_ff.resync
               || (sync_lost && !st_ff.sctl[SY_NOAUTO_BIT]))
            begin
               nxt_st.sync = SY_HUNT;
            end
         end
         default:
         begin
            nxt_st.sync = SY_OFF;
         end
      endcase
      nxt_st.rdata = 8'h00;
      if (rd_en)
      begin
         unique case (addr)
            OFS_IBUS: nxt_st.rdata = st_ff.ibus;
            OFS_MON_SEL: nxt_st.rdata = st_ff.mon_sel;
            OFS_TEST_CTRL: nxt_st.rdata = st_ff.tctl;
            OFS_SUPPRESS: nxt_st.rdata = st_ff.supp;
            OFS_SYNC_CTRL: nxt_st.rdata = st_ff.sctl;
            OFS_STATUS: nxt_st.rdata = st_ff.status;
            OFS_MON_VALUE: nxt_st.rdata = st_ff.mon_val;
            default: nxt_st.rdata = 8'h00;
         endcase
      end
   end
   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         st_ff <= '{ibus: RST_REG, mon_sel: RST_REG, tctl: RST_REG,
            supp: RST_REG, sctl: RST_REG, status: RST_REG,
            mon_val: RST_REG, rdata: 8'h00, fc: 8'h00, zrun: 5'h00,
            lost_d: 1'b0, resync: 1'b0, sync: SY_OFF};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = st_ff.rdata;
   assign interleave_mode_select = st_ff.ibus[IB_MODE_BIT];
   assign interleave_bus_enable = st_ff.ibus[IB_EN_BIT];
   assign bus_position_field = st_ff.ibus[IB_POS_LSB +: 3];
   assign bus_size_field = st_ff.ibus[IB_SIZE_LSB +: 2];
   always_comb
   begin
      unique case (bus_size_field)
         2'b00: bus_device_count = 4'h2;
         2'b01: bus_device_count = 4'h4;
         2'b10: bus_device_count = 4'h8;
         default: bus_device_count = 4'h0;
      endcase
   end
   assign bus_position_ok = interleave_bus_enable
      && {1'b0, bus_position_field} < bus_device_count;
   assign monitor_channel_select = st_ff.mon_sel[4:0];
   assign channel_monitor_value = st_ff.mon_val;
   assign test_port_direction = st_ff.tctl[TP_DIR_BIT];
   assign test_port_unframed_select = st_ff.tctl[TP_UNFR_BIT];
   assign test_port_enable = st_ff.tctl[TP_EN_BIT];
   logic tp_slot_ok;
   assign tp_slot_ok = tx_fbit_slot ? test_port_unframed_select
      : !st_ff.supp[tx_bit_pos];
   assign tp_insert_tx = test_port_enable && !test_port_direction
      && tp_slot_ok;
   assign tp_insert_rx = test_port_enable && test_port_direction
      && tp_slot_ok;
   assign tx_synchronizer_enable = st_ff.sctl[SY_EN_BIT];
   assign crc4_search = e1_mode && st_ff.sctl[SY_CRC4_BIT]
      && st_ff.sync == SY_HUNT && tx_synchronizer_enable;
   assign auto_resync_en = tx_synchronizer_enable
      && !st_ff.sctl[SY_NOAUTO_BIT];
   assign resync_pulse = st_ff.resync;
   assign sync_searching = st_ff.sync == SY_HUNT;
   assign status_pending = st_ff.status;
   // ****************************************
   // Checks
   // ****************************************
   default clocking tpc_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   chk_full_set: assert property (es_delete_evt |=> st_ff.status[7])
      else $error("full flag not set");
   chk_empty_set: assert property (es_repeat_evt |=> st_ff.status[6])
      else $error("empty flag not set");
   chk_slip_set: assert property (
      (es_delete_evt || es_repeat_evt) |=> st_ff.status[5])
      else $error("slip flag not set");
   chk_loss_hold: assert property (
      clk_lost[*2] |-> st_ff.status[0])
      else $error("loss flag dropped while lost");
   chk_restored_set: assert property (
      $fell(clk_lost) |=> st_ff.status[1])
      else $error("restored flag not set");
   chk_flag_sticky: assert property (
      st_ff.status[7] && !(wr_en && addr == OFS_STATUS && wdata[7])
      |=> st_ff.status[7])
      else $error("flag lost without clear");
   chk_resync_edge: assert property (
      resync_pulse |-> $past(wr_sync) && !$past(st_ff.sctl[0])
      && st_ff.sctl[0])
      else $error("resync without rising write");
   chk_resync_once: assert property (
      resync_pulse |=> !resync_pulse)
      else $error("resync longer than one cycle");
   chk_crc4_mode: assert property (
      crc4_search |-> e1_mode && tx_synchronizer_enable)
      else $error("crc4 search outside E1");
   chk_sync_off: assert property (
      !tx_synchronizer_enable[*2] |-> st_ff.sync == SY_OFF)
      else $error("synchronizer runs while disabled");
   chk_mon_select: assert property (
      wr_en && addr == OFS_MON_SEL
      |=> monitor_channel_select == $past(wdata[4:0]))
      else $error("monitor select not stored");
   chk_tp_route: assert property (
      tp_insert_rx |-> test_port_enable && test_port_direction
      && !tp_insert_tx)
      else $error("test port misrouted");
   cov_resync: cover property (resync_pulse ##[1:20] sync_searching);
   cov_loss_clear: cover property (st_ff.status[0] ##[1:400]
      st_ff.status[1]);
   cov_lock: cover property (sync_searching ##1 st_ff.sync == SY_LOCK);
endmodule
`default_nettype wire

// ---- verif/tpc_tb.sv ----
// Purpose: Self-checking bench for the transmit port control bank
// Assumes: 125 MHz clk, synchronous active-low reset
// Notes: Line clock toggles every 40 cycles unless stopped
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import tpc_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic clk, rstn, wr_en, rd_en, e1_mode, esf_mode, carrier_mf_enable;
   logic frame_pulse, es_delete_evt, es_repeat_evt, tx_data_bit;
   logic tx_bit_valid, tx_fbit_slot, tx_chan_valid, sync_found, sync_lost;
   logic tx_line_clock_input = 1'b0, line_run = 1'b1;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wdata, rdata, tx_chan_data, channel_monitor_value;
   logic [7:0] status_pending;
   logic [2:0] tx_bit_pos, bus_position_field;
   logic [4:0] tx_chan_num, monitor_channel_select;
   logic interleave_mode_select, interleave_bus_enable, bus_position_ok;
   logic [1:0] bus_size_field;
   logic [3:0] bus_device_count;
   logic test_port_direction, test_port_unframed_select, test_port_enable;
   logic tp_insert_tx, tp_insert_rx, tx_synchronizer_enable, crc4_search;
   logic auto_resync_en, resync_pulse, sync_searching;
   int fails = 0, cmp_count = 0, cycles = 0, lck = 0;
   tpc_port_ctrl DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .e1_mode(e1_mode),
      .esf_mode(esf_mode), .carrier_mf_enable(carrier_mf_enable),
      .frame_pulse(frame_pulse), .es_delete_evt(es_delete_evt),
      .es_repeat_evt(es_repeat_evt), .tx_data_bit(tx_data_bit),
      .tx_bit_valid(tx_bit_valid), .tx_bit_pos(tx_bit_pos),
      .tx_fbit_slot(tx_fbit_slot), .tx_chan_num(tx_chan_num),
      .tx_chan_data(tx_chan_data), .tx_chan_valid(tx_chan_valid),
      .sync_found(sync_found), .sync_lost(sync_lost),
      .tx_line_clock_input(tx_line_clock_input),
      .interleave_mode_select(interleave_mode_select),
      .interleave_bus_enable(interleave_bus_enable),
      .bus_position_field(bus_position_field),
      .bus_size_field(bus_size_field), .bus_device_count(bus_device_count),
      .bus_position_ok(bus_position_ok),
      .monitor_channel_select(monitor_channel_select),
      .channel_monitor_value(channel_monitor_value),
      .test_port_direction(test_port_direction),
      .test_port_unframed_select(test_port_unframed_select),
      .test_port_enable(test_port_enable), .tp_insert_tx(tp_insert_tx),
      .tp_insert_rx(tp_insert_rx),
      .tx_synchronizer_enable(tx_synchronizer_enable),
      .crc4_search(crc4_search), .auto_resync_en(auto_resync_en),
      .resync_pulse(resync_pulse), .sync_searching(sync_searching),
      .status_pending(status_pending));
   // ****************************************
   // Clock, line clock, timeout
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      lck = (lck == 39) ? 0 : lck + 1;
      if (line_run && lck == 0)
         tx_line_clock_input <= ~tx_line_clock_input;
      if (cycles == 20000)
      begin
         fails++;
         end_of_test();
      end
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
                  exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp,
                        input string what);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp, what);
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic frames(input int n, output int h[8]);
      logic [7:0] d;
      h = '{default: 0};
      repeat (n)
      begin
         @(posedge clk);
         frame_pulse <= 1'b1;
         @(posedge clk);
         frame_pulse <= 1'b0;
         rd(OFS_STATUS, d);
         for (int b = 0; b < 8; b++)
            if (d[b] === 1'b1)
               h[b]++;
         if (d !== 8'h00)
            wr(OFS_STATUS, d);
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk({4'h0, bus_device_count}, 8'h02, "count after reset");
      rdchk(OFS_IBUS, 8'h00, "ibus reset");
      rdchk(OFS_MON_SEL, 8'h00, "monsel reset");
      rdchk(OFS_TEST_CTRL, 8'h00, "test reset");
      rdchk(OFS_SUPPRESS, 8'h00, "suppress reset");
      rdchk(OFS_SYNC_CTRL, 8'h00, "sync reset");
      rdchk(OFS_STATUS, 8'h00, "status reset");
      wr(12'h18C, 8'hFF);
      rdchk(12'h18C, 8'h00, "unmapped");
      $display("reset test done");
   endtask
   task automatic t_ibus();
      logic [3:0] cnt[4] = '{4'h2, 4'h4, 4'h8, 4'h0};
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_IBUS, {1'b1, 2'(c), 5'b11101});
         chk({6'h0, bus_size_field}, 8'(c), "size");
         chk({4'h0, bus_device_count}, {4'h0, cnt[c]}, "count");
         chk({7'h0, bus_position_ok}, {7'h0, c == 2}, "pos ok");
         chk({7'h0, interleave_mode_select}, 8'h01, "mode");
         chk({7'h0, interleave_bus_enable}, 8'h01, "enable");
         chk({5'h0, bus_position_field}, 8'h05, "position");
         rdchk(OFS_IBUS, {1'b0, 2'(c), 5'b11101}, "ibus read");
      end
      wr(OFS_IBUS, 8'h07);
      chk({6'h0, interleave_mode_select, interleave_bus_enable}, 8'h00,
          "ibus off");
      chk({7'h0, bus_position_ok}, 8'h00, "disabled pos");
      $display("interleave test done");
   endtask
   task automatic t_monitor();
      wr(OFS_MON_SEL, 8'hFF);
      chk({3'h0, monitor_channel_select}, 8'h1F, "sel 32");
      rdchk(OFS_MON_SEL, 8'h1F, "sel read");
      @(posedge clk);
      tx_chan_num <= 5'd31;
      tx_chan_data <= 8'hA5;
      tx_chan_valid <= 1'b1;
      @(posedge clk);
      tx_chan_num <= 5'd0;
      tx_chan_data <= 8'h3C;
      @(posedge clk);
      tx_chan_valid <= 1'b0;
      rdchk(OFS_MON_VALUE, 8'hA5, "channel 32 data");
      chk(channel_monitor_value, 8'hA5, "monitor out");
      $display("monitor test done");
   endtask
   task automatic t_test_port();
      wr(OFS_TEST_CTRL, 8'h01);
      chk({6'h0, tp_insert_tx, tp_insert_rx}, 8'h02, "tx on");
      @(posedge clk);
      tx_fbit_slot <= 1'b1;
      tick();
      chk({7'h0, tp_insert_tx}, 8'h00, "framed skip");
      wr(OFS_TEST_CTRL, 8'h03);
      chk({7'h0, tp_insert_tx}, 8'h01, "unframed fill");
      wr(OFS_SUPPRESS, 8'h80);
      @(posedge clk);
      tx_fbit_slot <= 1'b0;
      tx_bit_pos <= 3'd7;
      tick();
      chk({7'h0, tp_insert_tx}, 8'h00, "msb suppressed");
      @(posedge clk);
      tx_bit_pos <= 3'd0;
      tick();
      chk({7'h0, tp_insert_tx}, 8'h01, "lsb used");
      wr(OFS_TEST_CTRL, 8'h05);
      chk({6'h0, tp_insert_tx, tp_insert_rx}, 8'h01, "rx path");
      chk({5'h0, test_port_direction, test_port_unframed_select,
           test_port_enable}, 8'h05, "fields");
      wr(OFS_TEST_CTRL, 8'hFC);
      chk({6'h0, tp_insert_tx, tp_insert_rx}, 8'h00, "port off");
      rdchk(OFS_TEST_CTRL, 8'h04, "ctrl read");
      $display("test port test done");
   endtask
   task automatic t_sync();
      e1_mode <= 1'b1;
      wr(OFS_SYNC_CTRL, 8'h0C);
      tick();
      chk({5'h0, sync_searching, auto_resync_en, crc4_search}, 8'h07,
          "hunt e1");
      @(posedge clk);
      e1_mode <= 1'b0;
      tick();
      chk({7'h0, crc4_search}, 8'h00, "no crc4 in t1");
      @(posedge clk);
      sync_found <= 1'b1;
      @(posedge clk);
      sync_found <= 1'b0;
      tick();
      chk({7'h0, sync_searching}, 8'h00, "locked");
      @(posedge clk);
      sync_lost <= 1'b1;
      tick();
      chk({7'h0, sync_searching}, 8'h01, "auto rehunt");
      @(posedge clk);
      {sync_lost, sync_found} <= 2'b01;
      @(posedge clk);
      sync_found <= 1'b0;
      wr(OFS_SYNC_CTRL, 8'h0D);
      chk({7'h0, resync_pulse}, 8'h01, "resync rise");
      tick();
      chk({6'h0, resync_pulse, sync_searching}, 8'h01, "rehunt");
      wr(OFS_SYNC_CTRL, 8'h0D);
      chk({7'h0, resync_pulse}, 8'h00, "no repeat");
      wr(OFS_SYNC_CTRL, 8'h0E);
      chk({7'h0, auto_resync_en}, 8'h00, "auto off");
      wr(OFS_SYNC_CTRL, 8'h00);
      tick();
      chk({6'h0, tx_synchronizer_enable, sync_searching}, 8'h00,
          "disabled");
      $display("sync test done");
   endtask
   task automatic t_elastic();
      @(posedge clk);
      es_delete_evt <= 1'b1;
      @(posedge clk);
      es_delete_evt <= 1'b0;
      rdchk(OFS_STATUS, 8'hA0, "delete");
      @(posedge clk);
      es_repeat_evt <= 1'b1;
      @(posedge clk);
      es_repeat_evt <= 1'b0;
      rdchk(OFS_STATUS, 8'hE0, "repeat");
      wr(OFS_STATUS, 8'h80);
      rdchk(OFS_STATUS, 8'h60, "clear full");
      chk(status_pending, 8'h60, "pending");
      wr(OFS_STATUS, 8'h60);
      rdchk(OFS_STATUS, 8'h00, "cleared");
      $display("elastic test done");
   endtask
   task automatic t_frames();
      int h[8];
      frames(72, h);
      chk(8'(h[2]), 8'd6, "d4 mf");
      chk(8'(h[4]), 8'd0, "carrier off");
      @(posedge clk);
      esf_mode <= 1'b1;
      carrier_mf_enable <= 1'b1;
      frames(72, h);
      chk(8'(h[2]), 8'd3, "esf mf");
      chk(8'(h[4]), 8'd1, "carrier");
      @(posedge clk);
      e1_mode <= 1'b1;
      frames(48, h);
      chk(8'(h[3]), 8'd24, "align");
      chk(8'(h[2]), 8'd3, "e1 mf");
      chk(8'(h[4]), 8'd0, "carrier e1");
      @(posedge clk);
      e1_mode <= 1'b0;
      $display("frame test done");
   endtask
   task automatic t_density();
      @(posedge clk);
      tx_bit_valid <= 1'b1;
      tx_data_bit <= 1'b1;
      @(posedge clk);
      tx_data_bit <= 1'b0;
      repeat (15) @(posedge clk);
      tx_bit_valid <= 1'b0;
      rdchk(OFS_STATUS, 8'h00, "15 zeros");
      @(posedge clk);
      tx_bit_valid <= 1'b1;
      @(posedge clk);
      tx_bit_valid <= 1'b0;
      rdchk(OFS_STATUS, 8'h08, "16 zeros");
      wr(OFS_STATUS, 8'h08);
      $display("density test done");
   endtask
   task automatic t_clk_loss();
      line_run = 1'b0;
      repeat (290) @(posedge clk);
      rdchk(OFS_STATUS, 8'h01, "loss");
      wr(OFS_STATUS, 8'h01);
      rdchk(OFS_STATUS, 8'h01, "loss holds");
      line_run = 1'b1;
      repeat (60) @(posedge clk);
      rdchk(OFS_STATUS, 8'h03, "restored");
      wr(OFS_STATUS, 8'h03);
      rdchk(OFS_STATUS, 8'h00, "clear all");
      $display("clock loss test done");
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {rstn, wr_en, rd_en, e1_mode, esf_mode, carrier_mf_enable} = '0;
      {frame_pulse, es_delete_evt, es_repeat_evt, tx_data_bit} = '0;
      {tx_bit_valid, tx_fbit_slot, tx_chan_valid, sync_found, sync_lost} = '0;
      {addr, wdata, tx_bit_pos, tx_chan_num, tx_chan_data} = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      tick();
      t_reset();
      t_ibus();
      t_monitor();
      t_test_port();
      t_sync();
      t_elastic();
      t_frames();
      t_density();
      t_clk_loss();
      end_of_test();
   end
endmodule
`default_nettype wire
